// ==== rtl/sfm_pkg.sv ====
package sfm_pkg;
    // fault category prefixes
    typedef enum logic [1:0] {
        SFM_CAT_NONE = 2'h0,
        SFM_CAT_F = 2'h1,
        SFM_CAT_E = 2'h2,
        SFM_CAT_U = 2'h3
    } sfm_cat_type;

    // displayed code numbers
    localparam logic [7:0] SFM_CODE_E24 = 8'h18;
    localparam logic [7:0] SFM_CODE_E36 = 8'h24;
    localparam logic [7:0] SFM_CODE_E39 = 8'h27;
    localparam logic [7:0] SFM_CODE_E41 = 8'h29;
    localparam logic [7:0] SFM_CODE_E60 = 8'h3c;
    localparam logic [7:0] SFM_CODE_E61 = 8'h3d;
    localparam logic [7:0] SFM_CODE_E62 = 8'h3e;
    localparam logic [7:0] SFM_CODE_E80 = 8'h50;
    localparam logic [7:0] SFM_CODE_E86 = 8'h56;
    localparam logic [7:0] SFM_CODE_E87 = 8'h57;
    localparam logic [7:0] SFM_CODE_E92 = 8'h5c;
    localparam logic [7:0] SFM_CODE_E93 = 8'h5d;
    localparam logic [7:0] SFM_CODE_E97 = 8'h61;
    localparam logic [7:0] SFM_CODE_E98 = 8'h62;
    localparam logic [7:0] SFM_CODE_U40 = 8'h28;
    localparam logic [7:0] SFM_CODE_U41 = 8'h29;
    localparam logic [7:0] SFM_CODE_U43 = 8'h2b;
    localparam logic [7:0] SFM_CODE_U51 = 8'h33;

    // timing
    localparam longint SFM_CLK_HZ = 40000000;
    localparam longint SFM_RES_HOLD_MS = 150000; // 2.5 min
    localparam longint SFM_MUTE_WIN_MS = 4000;   // 4 s
    localparam longint SFM_RES_HOLD_CYC = SFM_RES_HOLD_MS * SFM_CLK_HZ / 1000;
    localparam longint SFM_MUTE_WIN_CYC = SFM_MUTE_WIN_MS * SFM_CLK_HZ / 1000;
    localparam int SFM_CNT_W = 33;
    localparam int SFM_NFLT = 18;

    // fault slots, lowest index wins display
    localparam int SFM_F_E41 = 0;
    localparam int SFM_F_E80 = 1;
    localparam int SFM_F_E87 = 2;
    localparam int SFM_F_U43 = 3;
    localparam int SFM_F_U51 = 4;
    localparam int SFM_F_E24 = 5;
    localparam int SFM_F_E36 = 6;
    localparam int SFM_F_E39 = 7;
    localparam int SFM_F_E60 = 8;
    localparam int SFM_F_E61 = 9;
    localparam int SFM_F_E62 = 10;
    localparam int SFM_F_E92 = 11;
    localparam int SFM_F_E93 = 12;
    localparam int SFM_F_E97 = 13;
    localparam int SFM_F_E98 = 14;
    localparam int SFM_F_U40 = 15;
    localparam int SFM_F_U41 = 16;
    localparam int SFM_F_INT = 17;

    typedef enum logic [2:0] {
        SFM_MS_IDLE = 3'h1,
        SFM_MS_WAIT = 3'h2,
        SFM_MS_MUTED = 3'h4
    } sfm_mute_type;
endpackage

// ==== rtl/sfm_monitor.sv ====
`timescale 1ns/10ps
module sfm_monitor #(
    parameter longint RES_HOLD_CYC = sfm_pkg::SFM_RES_HOLD_CYC,
    parameter longint MUTE_WIN_CYC = sfm_pkg::SFM_MUTE_WIN_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // signal line and read-back
    input wire logic sig_line_drv,
    input wire logic sig_line_rb,
    input wire logic other_line_drv,
    // field switchover pair
    input wire logic fswitch_a,
    input wire logic fswitch_b,
    input wire logic fswitch_strobe,
    // reset button and mode
    input wire logic reset_button,
    input wire logic [2:0] mode_sel,
    input wire logic supply_reversed,
    input wire logic startup_done,
    // internal condition reports
    input wire logic beam_cfg_fault,
    input wire logic resp_time_over,
    input wire logic blank_overlap,
    input wire logic [1:0] chan_corrupt,
    input wire logic internal_fault,
    // linked upstream safety outputs
    input wire logic link_safety_switch_output_skew,
    input wire logic link_no_pulses,
    // muting and protective field
    input wire logic mute_a,
    input wire logic mute_b,
    input wire logic field_clear,
    // results
    output logic safety_switch_output_a,
    output logic safety_switch_output_b,
    output logic muting_active,
    output logic locked,
    output sfm_pkg::sfm_cat_type code_cat,
    output logic [7:0] code_num
);
    import sfm_pkg::*;

    logic [SFM_NFLT-1:0] flt_q, flt_d, cond;
    logic [SFM_CNT_W-1:0] res_cnt_q, res_cnt_d, mw_cnt_q, mw_cnt_d;
    logic [2:0] mode_q, mode_d;
    logic run_q, run_d, other_q, lk_q, lk_d;
    logic ma_q, mb_q;
    logic mute_refuse_q, mute_refuse_d;
    sfm_mute_type ms_q, ms_d;
    sfm_cat_type cat_d;
    logic [7:0] num_d;
    logic outs_off;

    function automatic logic [7:0] code_of(input int idx);
        unique case (idx)
            SFM_F_E41: code_of = SFM_CODE_E41;
            SFM_F_E80: code_of = SFM_CODE_E80;
            SFM_F_E87: code_of = SFM_CODE_E87;
            SFM_F_U43: code_of = SFM_CODE_U43;
            SFM_F_U51: code_of = SFM_CODE_U51;
            SFM_F_E24: code_of = SFM_CODE_E24;
            SFM_F_E36: code_of = SFM_CODE_E36;
            SFM_F_E39: code_of = SFM_CODE_E39;
            SFM_F_E60: code_of = SFM_CODE_E60;
            SFM_F_E61: code_of = SFM_CODE_E61;
            SFM_F_E62: code_of = SFM_CODE_E62;
            SFM_F_E92: code_of = SFM_CODE_E92;
            SFM_F_E93: code_of = SFM_CODE_E93;
            SFM_F_E97: code_of = SFM_CODE_E97;
            SFM_F_E98: code_of = SFM_CODE_E98;
            SFM_F_U40: code_of = SFM_CODE_U40;
            SFM_F_U41: code_of = SFM_CODE_U41;
            default: code_of = 8'h00;
        endcase
    endfunction

    function automatic sfm_cat_type cat_of(input int idx);
        if (idx == SFM_F_INT) begin
            cat_of = SFM_CAT_F;
        end else if (idx == SFM_F_U43 || idx == SFM_F_U51 ||
                     idx == SFM_F_U40 || idx == SFM_F_U41) begin
            cat_of = SFM_CAT_U;
        end else begin
            cat_of = SFM_CAT_E;
        end
    endfunction

    // locking slots never clear without a reset (restart)
    function automatic logic is_lock(input int idx);
        is_lock = (idx == SFM_F_E41) || (idx == SFM_F_E80) ||
                  (idx == SFM_F_E87) || (idx == SFM_F_INT);
    endfunction

    // condition detection
    always_comb begin
        cond = '0;
        // mismatch only counts when the other line moved in the same cycle
        cond[SFM_F_E24] = (sig_line_drv != sig_line_rb) &&
                          (other_line_drv != other_q);
        cond[SFM_F_E36] = fswitch_strobe && (fswitch_a != fswitch_b);
        // released button must clear at once, the count only resets later
        cond[SFM_F_E39] = reset_button &&
                          (res_cnt_q >= SFM_CNT_W'(RES_HOLD_CYC));
        cond[SFM_F_E41] = run_q && supply_reversed;
        cond[SFM_F_E80] = !run_q && startup_done && reset_button;
        cond[SFM_F_E87] = run_q && (mode_sel != mode_q) &&
                          !supply_reversed;
        cond[SFM_F_E60] = beam_cfg_fault;
        cond[SFM_F_E61] = resp_time_over;
        cond[SFM_F_E62] = blank_overlap;
        cond[SFM_F_E92] = chan_corrupt[0];
        cond[SFM_F_E93] = chan_corrupt[1];
        cond[SFM_F_E97] = link_safety_switch_output_skew;
        cond[SFM_F_E98] = link_no_pulses;
        cond[SFM_F_U40] = (ms_q == SFM_MS_IDLE) && (mute_a != ma_q) &&
                          (mute_b != mb_q);
        cond[SFM_F_U41] = (ms_q == SFM_MS_WAIT) &&
                          (mw_cnt_q >= SFM_CNT_W'(MUTE_WIN_CYC));
        cond[SFM_F_U43] = (ms_q == SFM_MS_MUTED) && !(mute_a && mute_b) &&
                          !field_clear;
        cond[SFM_F_U51] = (mute_a ^ mute_b) && !field_clear &&
                          (ms_q != SFM_MS_MUTED);
        cond[SFM_F_INT] = internal_fault;
    end

    // fault flags: locking ones stick, auto ones follow condition
    always_comb begin
        for (int i = 0; i < SFM_NFLT; i++) begin
            if (is_lock(i)) begin
                flt_d[i] = flt_q[i] | cond[i];
            end else if (i == SFM_F_U43 || i == SFM_F_U51) begin
                // output-off usage faults hold until field clear again
                flt_d[i] = cond[i] | (flt_q[i] & !field_clear);
            end else begin
                flt_d[i] = cond[i];
            end
        end
        lk_d = |(flt_d & {1'b1, 13'h0000, 4'h7});
    end

    // timers, mode capture and muting sequence
    always_comb begin
        res_cnt_d = reset_button ? res_cnt_q : '0;
        if (reset_button && res_cnt_q < SFM_CNT_W'(RES_HOLD_CYC)) begin
            res_cnt_d = res_cnt_q + SFM_CNT_W'(1);
        end
        run_d = run_q | (startup_done & !reset_button);
        mode_d = run_q ? mode_q : mode_sel;
        mw_cnt_d = '0;
        ms_d = ms_q;
        mute_refuse_d = mute_refuse_q;
        // refusal lasts until the protective field is violated
        if (!field_clear) begin
            mute_refuse_d = 1'b0;
        end
        unique case (ms_q)
            SFM_MS_IDLE: begin
                if (cond[SFM_F_U40]) begin
                    mute_refuse_d = 1'b1;
                end else if ((mute_a ^ mute_b) && !mute_refuse_q) begin
                    ms_d = SFM_MS_WAIT;
                end
            end
            SFM_MS_WAIT: begin
                mw_cnt_d = mw_cnt_q + SFM_CNT_W'(1);
                if (cond[SFM_F_U41]) begin
                    ms_d = SFM_MS_IDLE;
                    mute_refuse_d = 1'b1;
                end else if (mute_a && mute_b) begin
                    ms_d = SFM_MS_MUTED;
                end else if (!mute_a && !mute_b) begin
                    ms_d = SFM_MS_IDLE;
                end
            end
            SFM_MS_MUTED: begin
                if (!(mute_a && mute_b)) begin
                    ms_d = SFM_MS_IDLE;
                end
            end
            default: ms_d = SFM_MS_IDLE;
        endcase
    end

    // display: highest priority active slot, category prefix per code
    always_comb begin
        cat_d = SFM_CAT_NONE;
        num_d = 8'h00;
        for (int i = SFM_NFLT - 1; i >= 0; i--) begin
            if (flt_q[i]) begin
                cat_d = cat_of(i);
                num_d = code_of(i);
            end
        end
    end

    // outputs off on any locking fault or field-breach usage fault
    assign outs_off = lk_q || flt_q[SFM_F_U43] || flt_q[SFM_F_U51] ||
                      (!field_clear && ms_q != SFM_MS_MUTED);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flt_q <= '0;
            res_cnt_q <= '0;
            mw_cnt_q <= '0;
            mode_q <= 3'h0;
            run_q <= 1'b0;
            other_q <= 1'b0;
            lk_q <= 1'b0;
            ma_q <= 1'b0;
            mb_q <= 1'b0;
            mute_refuse_q <= 1'b0;
            ms_q <= SFM_MS_IDLE;
            code_cat <= SFM_CAT_NONE;
            code_num <= 8'h00;
            safety_switch_output_a <= 1'b0;
            safety_switch_output_b <= 1'b0;
            muting_active <= 1'b0;
        end else begin
            flt_q <= flt_d;
            res_cnt_q <= res_cnt_d;
            mw_cnt_q <= mw_cnt_d;
            mode_q <= mode_d;
            run_q <= run_d;
            other_q <= other_line_drv;
            lk_q <= lk_d;
            ma_q <= mute_a;
            mb_q <= mute_b;
            mute_refuse_q <= mute_refuse_d;
            ms_q <= ms_d;
            code_cat <= cat_d;
            code_num <= num_d;
            safety_switch_output_a <= run_q && !outs_off;
            safety_switch_output_b <= run_q && !outs_off;
            muting_active <= (ms_d == SFM_MS_MUTED);
        end
    end

    assign locked = lk_q;

    // checks
    lock_holds_a: assert property (@(posedge clk) disable iff (!rst_n)
        lk_q |=> lk_q) else $error("lock released without restart");
    lock_outs_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        lk_q |=> !safety_switch_output_a && !safety_switch_output_b)
        else $error("outputs on while locked");
    e87_lock_a: assert property (@(posedge clk) disable iff (!rst_n)
        cond[SFM_F_E87] |=> flt_q[SFM_F_E87] ##1 lk_q)
        else $error("mode change did not lock");
    e39_time_a: assert property (@(posedge clk) disable iff (!rst_n)
        !reset_button |=> !flt_q[SFM_F_E39])
        else $error("e39 without held button");
    e24_auto_a: assert property (@(posedge clk) disable iff (!rst_n)
        !cond[SFM_F_E24] |=> !flt_q[SFM_F_E24])
        else $error("e24 not auto cleared");
    u51_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        flt_q[SFM_F_U51] |=> !safety_switch_output_a)
        else $error("u51 left outputs on");
    u43_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        cond[SFM_F_U43] |=> ##1 !safety_switch_output_b)
        else $error("u43 left outputs on");
    u40_refuse_a: assert property (@(posedge clk) disable iff (!rst_n)
        cond[SFM_F_U40] && field_clear |=> mute_refuse_q && !muting_active)
        else $error("muting not refused after u40");
    u41_refuse_a: assert property (@(posedge clk) disable iff (!rst_n)
        cond[SFM_F_U41] |=> ms_q == SFM_MS_IDLE)
        else $error("late muting accepted");
    cat_map_a: assert property (@(posedge clk) disable iff (!rst_n)
        flt_q == (18'h1 << SFM_F_U51) |=> code_cat == SFM_CAT_U &&
        code_num == SFM_CODE_U51) else $error("wrong category");
    e36_auto_a: assert property (@(posedge clk) disable iff (!rst_n)
        cond[SFM_F_E36] |=> flt_q[SFM_F_E36])
        else $error("e36 missed");

    mute_ok_c: cover property (@(posedge clk) disable iff (!rst_n)
        ms_q == SFM_MS_WAIT ##1 ms_q == SFM_MS_MUTED);
    lock_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(lk_q));
    u41_c: cover property (@(posedge clk) disable iff (!rst_n)
        cond[SFM_F_U41]);
    u51_c: cover property (@(posedge clk) disable iff (!rst_n)
        $rose(flt_q[SFM_F_U51]));
endmodule

// ==== test/sfm_mute_partner.sv ====
`timescale 1ns/10ps
// muting sensor pair and the controller of the field switchover pair
module sfm_mute_partner (
    // clock
    input wire logic clk,
    // muting sensors
    output logic mute_a,
    output logic mute_b,
    // field switchover pair
    output logic fswitch_a,
    output logic fswitch_b,
    output logic fswitch_strobe
);
    initial begin
        mute_a = 1'b0;
        mute_b = 1'b0;
        fswitch_a = 1'b0;
        fswitch_b = 1'b0;
        fswitch_strobe = 1'b0;
    end
    task automatic mute_half();
        @(posedge clk);
        mute_a <= 1'b1;
    endtask
    task automatic mute_second();
        @(posedge clk);
        mute_b <= 1'b1;
    endtask
    // gap 0 stands for shorted sensor lines switching together
    task automatic mute_on(input int gap);
        if (gap == 0) begin
            @(posedge clk);
            mute_a <= 1'b1;
            mute_b <= 1'b1;
        end else begin
            mute_half();
            repeat (gap - 1) @(posedge clk);
            mute_second();
        end
    endtask
    task automatic mute_off();
        @(posedge clk);
        mute_a <= 1'b0;
        mute_b <= 1'b0;
    endtask
    // a faulty controller may leave the pair apart at the sample point
    task automatic fsw(input logic a, input logic b);
        @(posedge clk);
        fswitch_a <= a;
        fswitch_b <= b;
        fswitch_strobe <= 1'b1;
        @(posedge clk);
        fswitch_strobe <= 1'b0;
    endtask
endmodule

// ==== test/safety_fault_code_monitor_bench.sv ====
`timescale 1ns/10ps
`define CHK(nm, e, g) begin \
    num_checks++; \
    if ((g) !== (e)) begin \
        miscompares++; \
        $display("[ERR] %s exp %0h got %0h", nm, e, g); \
    end \
end
module safety_fault_code_monitor_bench;
    import sfm_pkg::*;
    // shortened counts keep the run brief
    localparam longint HOLD = 50;
    localparam longint WIN = 20;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sig_line_drv = 1'b0, sig_line_rb = 1'b0, other_line_drv = 1'b0;
    logic reset_button = 1'b0, supply_reversed = 1'b0, startup_done = 1'b0;
    logic beam_cfg_fault = 1'b0, resp_time_over = 1'b0, blank_overlap = 1'b0;
    logic internal_fault = 1'b0, link_safety_switch_output_skew = 1'b0, link_no_pulses = 1'b0;
    logic field_clear = 1'b1;
    logic [2:0] mode_sel = 3'h0;
    logic [1:0] chan_corrupt = 2'h0;
    logic mute_a, mute_b, fswitch_a, fswitch_b, fswitch_strobe;
    logic safety_switch_output_a, safety_switch_output_b, muting_active, locked;
    sfm_cat_type code_cat;
    logic [7:0] code_num;
    logic [7:0] auto_num [8] = '{SFM_CODE_E60, SFM_CODE_E61, SFM_CODE_E62,
        SFM_CODE_E92, SFM_CODE_E93, SFM_CODE_E97, SFM_CODE_E98, 8'h00};
    int miscompares = 0;
    int num_checks = 0;
    int cycles = 0;
    always #12.5 clk = ~clk;
    sfm_monitor #(.RES_HOLD_CYC(HOLD), .MUTE_WIN_CYC(WIN)) sfm_monitor_i (
        .clk(clk), .rst_n(rst_n),
        .sig_line_drv(sig_line_drv), .sig_line_rb(sig_line_rb),
        .other_line_drv(other_line_drv),
        .fswitch_a(fswitch_a), .fswitch_b(fswitch_b),
        .fswitch_strobe(fswitch_strobe),
        .reset_button(reset_button), .mode_sel(mode_sel),
        .supply_reversed(supply_reversed), .startup_done(startup_done),
        .beam_cfg_fault(beam_cfg_fault), .resp_time_over(resp_time_over),
        .blank_overlap(blank_overlap), .chan_corrupt(chan_corrupt),
        .internal_fault(internal_fault), .link_safety_switch_output_skew(link_safety_switch_output_skew),
        .link_no_pulses(link_no_pulses),
        .mute_a(mute_a), .mute_b(mute_b), .field_clear(field_clear),
        .safety_switch_output_a(safety_switch_output_a),
        .safety_switch_output_b(safety_switch_output_b),
        .muting_active(muting_active), .locked(locked),
        .code_cat(code_cat), .code_num(code_num));
    sfm_mute_partner sfm_mute_partner_i (.clk(clk),
        .mute_a(mute_a), .mute_b(mute_b), .fswitch_a(fswitch_a),
        .fswitch_b(fswitch_b), .fswitch_strobe(fswitch_strobe));
    task automatic report_and_stop();
        if (miscompares == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            report_and_stop();
        end
    end
    task automatic look(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // code number only defined for external and usage faults
    task automatic code(input sfm_cat_type c, input logic [7:0] n);
        `CHK("code_cat", c, code_cat)
        if (c == SFM_CAT_E || c == SFM_CAT_U) `CHK("code_num", n, code_num)
    endtask
    task automatic state(input logic lk, input logic on);
        `CHK("locked", lk, locked)
        `CHK("out_a", on, safety_switch_output_a)
        `CHK("out_b", on, safety_switch_output_b)
    endtask
    task automatic restart(input logic btn);
        @(posedge clk);
        rst_n <= 1'b0;
        startup_done <= 1'b0;
        reset_button <= btn;
        supply_reversed <= 1'b0;
        field_clear <= 1'b1;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        startup_done <= 1'b1;
        look(4);
    endtask
    task automatic auto_in(input int i, input logic v);
        case (i)
            0: beam_cfg_fault <= v;
            1: resp_time_over <= v;
            2: blank_overlap <= v;
            3: chan_corrupt <= {1'b0, v};
            4: chan_corrupt <= {v, 1'b0};
            5: link_safety_switch_output_skew <= v;
            6: link_no_pulses <= v;
            default: internal_fault <= v;
        endcase
    endtask
    task automatic t_auto();
        for (int i = 0; i < 7; i++) begin
            @(posedge clk);
            auto_in(i, 1'b1);
            look(3);
            code(SFM_CAT_E, auto_num[i]);
            `CHK("locked", 1'b0, locked)
            @(posedge clk);
            auto_in(i, 1'b0);
            look(3);
            code(SFM_CAT_NONE, 8'h00);
        end
        // internal faults lock until restart
        @(posedge clk);
        auto_in(7, 1'b1);
        look(3);
        code(SFM_CAT_F, 8'h00);
        @(posedge clk);
        auto_in(7, 1'b0);
        look(3);
        code(SFM_CAT_F, 8'h00);
        state(1'b1, 1'b0);
        restart(1'b0);
        state(1'b0, 1'b1);
    endtask
    task automatic t_lines();
        @(posedge clk);
        sig_line_drv <= 1'b1;
        look(3);
        code(SFM_CAT_NONE, 8'h00);
        @(posedge clk);
        other_line_drv <= 1'b1;
        look(2);
        code(SFM_CAT_E, SFM_CODE_E24);
        @(posedge clk);
        sig_line_rb <= 1'b1;
        look(3);
        code(SFM_CAT_NONE, 8'h00);
        sfm_mute_partner_i.fsw(1'b1, 1'b0);
        look(1);
        code(SFM_CAT_E, SFM_CODE_E36);
        sfm_mute_partner_i.fsw(1'b1, 1'b1);
        look(2);
        code(SFM_CAT_NONE, 8'h00);
        @(posedge clk);
        reset_button <= 1'b1;
        look(45);
        code(SFM_CAT_NONE, 8'h00);
        look(10);
        code(SFM_CAT_E, SFM_CODE_E39);
        @(posedge clk);
        reset_button <= 1'b0;
        look(3);
        code(SFM_CAT_NONE, 8'h00);
    endtask
    task automatic t_lock();
        @(posedge clk);
        supply_reversed <= 1'b1;
        look(3);
        code(SFM_CAT_E, SFM_CODE_E41);
        @(posedge clk);
        supply_reversed <= 1'b0;
        look(3);
        state(1'b1, 1'b0);
        restart(1'b0);
        @(posedge clk);
        mode_sel <= 3'h1;
        look(4);
        code(SFM_CAT_E, SFM_CODE_E87);
        state(1'b1, 1'b0);
        restart(1'b1);
        code(SFM_CAT_E, SFM_CODE_E80);
        @(posedge clk);
        reset_button <= 1'b0;
        look(3);
        state(1'b1, 1'b0);
        restart(1'b0);
        state(1'b0, 1'b1);
    endtask
    task automatic t_mute();
        sfm_mute_partner_i.mute_on(18);
        look(2);
        `CHK("muting", 1'b1, muting_active)
        @(posedge clk);
        field_clear <= 1'b0;
        look(3);
        state(1'b0, 1'b1);
        sfm_mute_partner_i.mute_off();
        look(3);
        code(SFM_CAT_U, SFM_CODE_U43);
        state(1'b0, 1'b0);
        @(posedge clk);
        field_clear <= 1'b1;
        look(4);
        state(1'b0, 1'b1);
        sfm_mute_partner_i.mute_half();
        @(posedge clk);
        field_clear <= 1'b0;
        look(3);
        code(SFM_CAT_U, SFM_CODE_U51);
        state(1'b0, 1'b0);
        sfm_mute_partner_i.mute_off();
        restart(1'b0);
        sfm_mute_partner_i.mute_on(0);
        look(2);
        code(SFM_CAT_U, SFM_CODE_U40);
        state(1'b0, 1'b1);
        sfm_mute_partner_i.mute_off();
        restart(1'b0);
        // second sensor late: refused even after it arrives
        sfm_mute_partner_i.mute_half();
        look(23);
        code(SFM_CAT_U, SFM_CODE_U41);
        sfm_mute_partner_i.mute_second();
        look(2);
        `CHK("muting", 1'b0, muting_active)
        state(1'b0, 1'b1);
    endtask
    initial begin
        restart(1'b0);
        state(1'b0, 1'b1);
        code(SFM_CAT_NONE, 8'h00);
        t_auto();
        t_lines();
        t_lock();
        t_mute();
        report_and_stop();
    end
endmodule
